//--- sdm_host_model.sv
// Serial host controller model that reads the table and the drive registers
`timescale 1ns/1ps
`default_nettype none
module sdm_host_model
  import sdm_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic so_i,
  input  wire logic so_oe_i,
  output logic      cs_n_o,
  output logic      sck_o,
  output logic      si_o
);
  // Serial clock half period in core cycles; the device needs at least 2
  localparam int HALF = 4;

  initial begin
    cs_n_o = 1'b1;
    sck_o  = 1'b0;
    si_o   = 1'b0;
  end

  task automatic half_wait();
    repeat (HALF) @(negedge core_clk_i);
  endtask

  // Mode 0: data set while the clock is low, taken on the rise
  task automatic put_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      si_o = b[i];
      half_wait();
      sck_o = 1'b1;
      half_wait();
      sck_o = 1'b0;
    end
  endtask

  task automatic get_byte(output logic [7:0] b);
    b = 8'h00;
    for (int i = 0; i < 8; i++) begin
      si_o = ~si_o;
      half_wait();
      // An undriven line reads as the inverse so a missing enable shows up
      b = {b[6:0], so_oe_i ? so_i : ~so_i};
      sck_o = 1'b1;
      half_wait();
      sck_o = 1'b0;
    end
  endtask

  // Whole frame: command, 24-bit address MSB first, optional data, reads
  task automatic frame(input logic [7:0] cmd, input logic [23:0] addr, input logic [7:0] wd,
                       input int nwr, input int nrd, output logic [31:0] rd, output logic oe);
    logic [7:0] b;
    rd = 32'h0000_0000;
    oe = 1'b0;
    cs_n_o = 1'b0;
    half_wait();
    put_byte(cmd);
    put_byte(addr[23:16]);
    put_byte(addr[15:8]);
    put_byte(addr[7:0]);
    if (nwr > 0) begin
      put_byte(wd);
    end
    for (int k = 0; k < nrd; k++) begin
      get_byte(b);
      rd = {rd[23:0], b};
    end
    oe = so_oe_i;
    half_wait();
    cs_n_o = 1'b1;
    si_o = ~si_o;
    half_wait();
  endtask
endmodule
`default_nettype wire

//--- sdm_pkg.sv
// Constants, types and lookups for the drive strength map block
package sdm_pkg;

  // ---------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_REG_WR = 8'h71;
  localparam logic [7:0] CMD_REG_RD = 8'h65;
  localparam logic [7:0] CMD_TBL_RD = 8'h5A;

  // ---------------------------------------------------------------
  // Register map and drive strength field
  // ---------------------------------------------------------------
  localparam logic [23:0] ADDR_VOL  = 24'h800005;
  localparam logic [23:0] ADDR_NV   = 24'h000005;
  localparam int          FLD_LSB   = 5;
  localparam int          FLD_W     = 3;
  localparam int          FLD_MSB   = FLD_LSB + FLD_W - 1;
  localparam logic [7:0]  NV_RST    = 8'h00;
  localparam logic [7:0]  VOL_RST   = 8'h00;
  localparam logic [7:0]  BYTE_ZERO = 8'h00;
  localparam int          BYTE_W    = 8;

  // ---------------------------------------------------------------
  // Field patterns and driver type codes
  // ---------------------------------------------------------------
  localparam logic [2:0] PAT_45   = 3'h0;
  localparam logic [2:0] PAT_30   = 3'h5;
  localparam logic [2:0] PAT_60   = 3'h3;
  localparam logic [2:0] PAT_90   = 3'h2;
  localparam logic [2:0] PAT_NONE = 3'h0;
  localparam logic [2:0] DT_45    = 3'h0;
  localparam logic [2:0] DT_30    = 3'h1;
  localparam logic [2:0] DT_60    = 3'h2;
  localparam logic [2:0] DT_90    = 3'h3;
  localparam logic [2:0] DT_BAD   = 3'h4;

  // ---------------------------------------------------------------
  // Discovery table words
  // ---------------------------------------------------------------
  localparam logic [1:0]  DSC_NBITS = 2'h3;
  localparam logic        DSC_RSVD  = 1'h0;
  localparam logic        DSC_ADDR  = 1'h1;
  localparam logic        DSC_NSUP  = 1'h0;
  localparam logic [2:0]  DSC_LSB   = 3'(FLD_LSB);
  localparam logic [7:0]  DSC_TOP   = {DSC_NBITS, DSC_RSVD, DSC_ADDR, DSC_NSUP, DSC_LSB};
  localparam logic [31:0] DW_VOL    = {DSC_TOP, ADDR_VOL[7:0], CMD_REG_RD, CMD_REG_WR};
  localparam logic [31:0] DW_NV     = {DSC_TOP, ADDR_NV[7:0], CMD_REG_RD, CMD_REG_WR};
  localparam logic [31:0] DW_PAT    = {PAT_45, PAT_30, PAT_60, PAT_90, PAT_NONE, 1'h0, 16'h0000};
  localparam logic [23:0] TBL_VOL   = 24'h0001BC;
  localparam logic [23:0] TBL_NV    = 24'h0001C0;
  localparam logic [23:0] TBL_PAT   = 24'h0001C4;
  localparam logic [23:0] LANE_MASK = 24'h000003;
  localparam logic [23:0] ADDR_STEP = 24'h000001;
  localparam logic [1:0]  ADDR_LAST = 2'h2;
  localparam logic [1:0]  ADDR_INC  = 2'h1;

  typedef enum logic [5:0] {
    ST_BOOT = 6'h01,
    ST_IDLE = 6'h02,
    ST_ADDR = 6'h04,
    ST_DIN  = 6'h08,
    ST_DOUT = 6'h10,
    ST_SKIP = 6'h20
  } sdm_state_e;

  function automatic logic [7:0] dw_byte(input logic [31:0] dw, input logic [1:0] lane);
    return dw[int'(lane) * BYTE_W +: BYTE_W];
  endfunction

  function automatic logic [7:0] sfdp_byte(input logic [23:0] a);
    logic [23:0] base;
    base = a & ~LANE_MASK;
    if (base == TBL_VOL) begin
      return dw_byte(DW_VOL, a[1:0]);
    end else if (base == TBL_NV) begin
      return dw_byte(DW_NV, a[1:0]);
    end else if (base == TBL_PAT) begin
      return dw_byte(DW_PAT, a[1:0]);
    end else begin
      return BYTE_ZERO;
    end
  endfunction

  function automatic logic [2:0] drv_decode(input logic [2:0] f);
    if (f == PAT_45) begin
      return DT_45;
    end else if (f == PAT_30) begin
      return DT_30;
    end else if (f == PAT_60) begin
      return DT_60;
    end else if (f == PAT_90) begin
      return DT_90;
    end else begin
      return DT_BAD;
    end
  endfunction

endpackage

//--- sdm_shift.sv
// Serial receive shifter with clock edge detection
`timescale 1ns/1ps
`default_nettype none
module sdm_shift
  import sdm_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       cs_n_i,
  input  wire logic       sck_i,
  input  wire logic       si_i,
  output logic [7:0]      byte_o,
  output logic            byte_vld_o,
  output logic            fall_o
);

  logic       sck_q;
  logic [2:0] cnt_q;
  logic [7:0] sh_q;
  logic       rise;

  assign rise = sck_i && !sck_q && !cs_n_i;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sck_q <= 1'b0;
    end else begin
      sck_q <= sck_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q      <= 3'h0;
      sh_q       <= BYTE_ZERO;
      byte_o     <= BYTE_ZERO;
      byte_vld_o <= 1'b0;
    end else begin
      byte_vld_o <= 1'b0;
      if (cs_n_i) begin
        cnt_q <= 3'h0;
      end else if (rise) begin
        cnt_q <= cnt_q + 3'h1;
        sh_q  <= {sh_q[6:0], si_i};
        if (cnt_q == 3'h7) begin
          byte_o     <= {sh_q[6:0], si_i};
          byte_vld_o <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fall_o <= 1'b0;
    end else begin
      fall_o <= !sck_i && sck_q && !cs_n_i;
    end
  end

endmodule
`default_nettype wire

//--- sdm_table.sv
// Discovery table lookup for the drive strength descriptors
`timescale 1ns/1ps
`default_nettype none
module sdm_table
  import sdm_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic [23:0] addr_i,
  output logic [7:0]       data_o
);

  assign data_o = sfdp_byte(addr_i);

  a_slot4_zero: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (addr_i == 24'h0001C6) |-> (data_o[3:1] == 3'h0))
    else $error("fifth driver slot not zero");

  a_pat_word: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    ((addr_i & ~LANE_MASK) == 24'h0001C4) |->
      (data_o == ((addr_i[1:0] == 2'h2) ? 8'hA0 : (addr_i[1:0] == 2'h3) ? 8'h15 : 8'h00)))
    else $error("pattern word byte wrong");

  a_desc_top: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (addr_i == 24'h0001BF || addr_i == 24'h0001C3) |-> (data_o == 8'hD5 && !data_o[5] && !data_o[3]))
    else $error("descriptor top byte wrong");

endmodule
`default_nettype wire

//--- sdm_top.sv
// Drive strength register pair with serial register and table access
`timescale 1ns/1ps
`default_nettype none
module sdm_top
  import sdm_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       cs_n_i,
  input  wire logic       sck_i,
  input  wire logic       si_i,
  output logic            so_o,
  output logic            so_oe_o,
  output logic [2:0]      drv_field_o,
  output logic [2:0]      drv_type_o
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  sdm_state_e  state_q;
  sdm_state_e  state_d;
  logic [7:0]  cmd_q;
  logic [23:0] addr_q;
  logic [23:0] addr_d;
  logic [1:0]  acnt_q;
  logic [7:0]  vol_q;
  logic [7:0]  nv_q;
  logic [7:0]  tx_q;
  logic        so_q;
  logic        so_oe_q;
  logic [2:0]  fld_q;
  logic [2:0]  dtype_q;
  logic [7:0]  rx_byte;
  logic        rx_vld;
  logic        sck_fall;
  logic [7:0]  tbl_byte;
  logic        wr_en;
  logic        ld_tx;
  logic        addr_done;

  function automatic logic cmd_known(input logic [7:0] c);
    return (c == CMD_REG_WR) || (c == CMD_REG_RD) || (c == CMD_TBL_RD);
  endfunction

  // ---------------------------------------------------------------
  // Serial front end and table
  // ---------------------------------------------------------------
  sdm_shift u_shift (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .cs_n_i     (cs_n_i),
    .sck_i      (sck_i),
    .si_i       (si_i),
    .byte_o     (rx_byte),
    .byte_vld_o (rx_vld),
    .fall_o     (sck_fall)
  );

  sdm_table u_table (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .addr_i     (addr_d),
    .data_o     (tbl_byte)
  );

  // ---------------------------------------------------------------
  // Command sequencer
  // ---------------------------------------------------------------
  assign addr_done = (state_q == ST_ADDR) && rx_vld && (acnt_q == ADDR_LAST);
  assign wr_en     = (state_q == ST_DIN) && rx_vld;
  assign ld_tx     = rx_vld && (state_d == ST_DOUT);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_BOOT: begin
        state_d = ST_IDLE;
      end
      ST_IDLE: begin
        if (rx_vld) begin
          state_d = cmd_known(rx_byte) ? ST_ADDR : ST_SKIP;
        end
      end
      ST_ADDR: begin
        if (addr_done) begin
          state_d = (cmd_q == CMD_REG_WR) ? ST_DIN : ST_DOUT;
        end
      end
      ST_DIN: begin
        if (rx_vld) begin
          state_d = ST_SKIP;
        end
      end
      default: begin
        state_d = state_q;
      end
    endcase
    if (cs_n_i && (state_q != ST_BOOT)) begin
      state_d = ST_IDLE;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= ST_BOOT;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmd_q <= BYTE_ZERO;
    end else if ((state_q == ST_IDLE) && rx_vld) begin
      cmd_q <= rx_byte;
    end
  end

  // ---------------------------------------------------------------
  // Address capture and auto increment
  // ---------------------------------------------------------------
  always_comb begin
    addr_d = addr_q;
    if (state_q == ST_ADDR) begin
      addr_d = {addr_q[15:0], rx_byte};
    end else if ((state_q == ST_DOUT) && (cmd_q == CMD_TBL_RD)) begin
      addr_d = addr_q + ADDR_STEP;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      addr_q <= 24'h000000;
      acnt_q <= 2'h0;
    end else begin
      if (state_q == ST_IDLE) begin
        acnt_q <= 2'h0;
      end else if ((state_q == ST_ADDR) && rx_vld) begin
        acnt_q <= acnt_q + ADDR_INC;
      end
      if (rx_vld && ((state_q == ST_ADDR) || (state_q == ST_DOUT))) begin
        addr_q <= addr_d;
      end
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  // Volatile copy follows the stored copy once, right after reset
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      vol_q <= VOL_RST;
    end else if (state_q == ST_BOOT) begin
      vol_q <= nv_q;
    end else if (wr_en && (addr_q == ADDR_VOL)) begin
      vol_q <= rx_byte;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      nv_q <= NV_RST;
    end else if (wr_en && (addr_q == ADDR_NV)) begin
      nv_q <= rx_byte;
    end
  end

  // ---------------------------------------------------------------
  // Read data path
  // ---------------------------------------------------------------
  function automatic logic [7:0] reg_byte(input logic [23:0] a, input logic [7:0] v,
                                          input logic [7:0] n);
    if (a == ADDR_VOL) begin
      return v;
    end else if (a == ADDR_NV) begin
      return n;
    end else begin
      return BYTE_ZERO;
    end
  endfunction

  // Next byte is loaded on the last rising edge, first bit leaves on the next fall
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_q <= BYTE_ZERO;
      so_q <= 1'b0;
    end else if (ld_tx) begin
      tx_q <= (cmd_q == CMD_TBL_RD) ? tbl_byte : reg_byte(addr_d, vol_q, nv_q);
    end else if (sck_fall && (state_q == ST_DOUT)) begin
      so_q <= tx_q[7];
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      so_oe_q <= 1'b0;
    end else begin
      so_oe_q <= (state_d == ST_DOUT);
    end
  end

  // ---------------------------------------------------------------
  // Drive strength outputs
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fld_q   <= PAT_45;
      dtype_q <= DT_45;
    end else begin
      fld_q   <= vol_q[FLD_MSB:FLD_LSB];
      dtype_q <= drv_decode(vol_q[FLD_MSB:FLD_LSB]);
    end
  end

  assign so_o        = so_q;
  assign so_oe_o     = so_oe_q;
  assign drv_field_o = fld_q;
  assign drv_type_o  = dtype_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_write_vol: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    ((state_q == ST_DIN) && rx_vld && (addr_q == ADDR_VOL))
      |=> (vol_q == $past(rx_byte)) && ($past(cmd_q) == 8'h71))
    else $error("volatile write not applied");

  a_write_nv: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    ((state_q == ST_DIN) && rx_vld && (addr_q == 24'h000005))
      |=> (nv_q == $past(rx_byte)))
    else $error("nonvolatile write not applied");

  a_read_vol: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (addr_done && (cmd_q == 8'h65) && ({addr_q[15:0], rx_byte} == 24'h800005))
      |=> (tx_q == $past(vol_q)) && so_oe_o)
    else $error("register read did not load volatile copy");

  a_plain_wr: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    ($past(state_q) != ST_BOOT) && (vol_q != $past(vol_q))
      |-> ($past(state_q) == ST_DIN) && ($past(addr_q) == 24'h800005))
    else $error("volatile field changed without addressed write");

  a_boot_copy: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (state_q == ST_BOOT) |=> (vol_q == $past(nv_q)) && (state_q == ST_IDLE))
    else $error("volatile copy not loaded after reset");

  a_field_pos: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    ((state_q == ST_DIN) && rx_vld && (addr_q == ADDR_VOL))
      |-> ##2 ({drv_field_o, 5'h00} == ($past(rx_byte, 2) & 8'hE0)))
    else $error("drive field not taken from bits 7 to 5");

  a_drv_45_30: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    ((drv_field_o == 3'h0) |-> (drv_type_o == DT_45))
      and ((drv_field_o == 3'h5) |-> (drv_type_o == DT_30)))
    else $error("45 or 30 ohm decode wrong");

  a_drv_60_90: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    ((drv_field_o == 3'h3) |-> (drv_type_o == DT_60))
      and ((drv_field_o == 3'h2) |-> (drv_type_o == DT_90)))
    else $error("60 or 90 ohm decode wrong");

  a_dtype_bad: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    !(drv_field_o inside {3'h0, 3'h5, 3'h3, 3'h2}) |-> (drv_type_o == DT_BAD))
    else $error("unlisted pattern not reported unsupported");

  a_oe_read_only: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    so_oe_o |-> ((cmd_q == 8'h65) || (cmd_q == 8'h5A)))
    else $error("data output enabled outside a read");

  a_so_on_fall: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (so_o != $past(so_o)) |-> $past(sck_fall))
    else $error("serial data changed away from a clock fall");

  a_nv_write_only: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (nv_q != $past(nv_q)) |-> ($past(wr_en) && ($past(addr_q) == 24'h000005)))
    else $error("nonvolatile copy changed without addressed write");

  a_tbl_load: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (ld_tx && (cmd_q == 8'h5A) && (addr_d == 24'h0001C7)) |=> (tx_q == 8'h15))
    else $error("table byte not loaded for transmit");

endmodule
`default_nettype wire

//--- testbench.sv
// Self-checking testbench for the drive strength register pair and table
`timescale 1ns/1ps
`default_nettype none
module testbench
  import sdm_pkg::*;
;
  localparam int LIMIT = 40000;

  logic        core_clk;
  logic        arst_n;
  logic        cs_n;
  logic        sck;
  logic        si;
  logic        so;
  logic        so_oe;
  logic [2:0]  drv_field;
  logic [2:0]  drv_type;
  logic [31:0] rd;
  logic        oe;
  int          n_fail;
  int          compares;
  int          cycles;
  logic [2:0]  pats [5];
  logic [2:0]  types [5];

  sdm_top DUT (
    .core_clk_i  (core_clk),
    .arst_n_i    (arst_n),
    .cs_n_i      (cs_n),
    .sck_i       (sck),
    .si_i        (si),
    .so_o        (so),
    .so_oe_o     (so_oe),
    .drv_field_o (drv_field),
    .drv_type_o  (drv_type)
  );

  sdm_host_model host (
    .core_clk_i (core_clk),
    .so_i       (so),
    .so_oe_i    (so_oe),
    .cs_n_o     (cs_n),
    .sck_o      (sck),
    .si_o       (si)
  );

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // ---------------------------------------------------------------
  // Reporting
  // ---------------------------------------------------------------
  task automatic end_of_test();
    $display("Summary: compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_port(input logic [2:0] got, input logic [2:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_fail++;
      end_of_test();
    end
  end

  // ---------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------
  task automatic reg_wr(input logic [23:0] a, input logic [7:0] v);
    host.frame(8'h71, a, v, 1, 0, rd, oe);
  endtask

  task automatic reg_rd(input logic [23:0] a, input logic [7:0] e);
    host.frame(8'h65, a, 8'h00, 0, 1, rd, oe);
    chk_data(rd, {24'h000000, e});
    chk_port({2'h0, oe}, 3'h1);
  endtask

  task automatic tbl_rd(input logic [23:0] a, input logic [31:0] e);
    host.frame(CMD_TBL_RD, a, 8'h00, 0, 4, rd, oe);
    chk_data(rd, e);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    n_fail = 0;
    compares = 0;
    cycles = 0;
    pats = '{3'h0, 3'h5, 3'h3, 3'h2, 3'h7};
    types = '{DT_45, DT_30, DT_60, DT_90, DT_BAD};
    arst_n = 1'b0;
    repeat (12) @(negedge core_clk);
    arst_n = 1'b1;
    repeat (3) @(negedge core_clk);
    chk_port(drv_field, 3'h0);
    chk_port(drv_type, DT_45);
    reg_rd(24'h000005, 8'h00);
    reg_rd(24'h800005, 8'h00);
    tbl_rd(24'h0001BC, 32'h716505D5);
    tbl_rd(24'h0001C0, 32'h716505D5);
    tbl_rd(24'h0001C4, 32'h0000A015);
    // Every documented pattern plus one unlisted pattern
    for (int i = 0; i < 5; i++) begin
      reg_wr(24'h800005, {pats[i], 5'h0A});
      chk_port(drv_field, pats[i]);
      chk_port(drv_type, types[i]);
      reg_rd(24'h800005, {pats[i], 5'h0A});
    end
    // Nonvolatile copy is separate from the live field
    reg_wr(24'h000005, 8'h60);
    reg_rd(24'h000005, 8'h60);
    chk_port(drv_field, 3'h7);
    // Unmapped register address is ignored and reads zero
    reg_wr(24'h000006, 8'hFF);
    reg_rd(24'h000006, 8'h00);
    reg_rd(24'h800005, 8'hEA);
    host.frame(8'h65, 24'h800005, 8'h00, 0, 2, rd, oe);
    chk_data(rd, 32'h0000EAEA);
    // Unknown command leaves the output undriven
    host.frame(8'h00, 24'h800005, 8'h00, 0, 1, rd, oe);
    chk_port({2'h0, oe}, 3'h0);
    chk_port(drv_field, 3'h7);
    // Reset in mid-run clears the stored copy to NV_RST and reloads the live field from it
    arst_n = 1'b0;
    repeat (2) @(negedge core_clk);
    arst_n = 1'b1;
    repeat (3) @(negedge core_clk);
    chk_port(drv_field, NV_RST[FLD_MSB:FLD_LSB]);
    reg_rd(24'h800005, NV_RST);
    end_of_test();
  end
endmodule
`default_nettype wire
